//--- hw/awf_pkg.sv
// package for the add-w-to-file execution block: constants, types, functional notes
// Functional notes
// - sum is working reg plus file reg; update N, OV, C, DC, Z flags
// - destination bit clear writes working reg, set writes file reg back
// - access bit clear resolves address inside fixed access bank
// - access bit set joins bank select register with eight-bit address
// - extended set, access clear, address at most 5fh: indexed literal offset mode
// - one word, one cycle of four quarters: decode, read, process, write
package awf_pkg;
  localparam logic [5:0] awf_opcode = 6'h09;  // upper six bits 0010_01
  localparam int awf_op_hi = 15;
  localparam int awf_op_lo = 10;
  localparam int awf_dest_bit = 9;
  localparam int awf_acc_bit = 8;
  localparam logic [7:0] awf_idx_limit = 8'h5f;
  localparam logic [7:0] awf_acc_split = 8'h60;  // access bank low half limit
  localparam logic [3:0] awf_acc_hi_bank = 4'hf;
  localparam logic [7:0] awf_w_reset = 8'h00;
  localparam int awf_flag_n = 4;
  localparam int awf_flag_ov = 3;
  localparam int awf_flag_z = 2;
  localparam int awf_flag_dc = 1;
  localparam int awf_flag_c = 0;

  typedef enum logic [1:0] {awf_q1, awf_q2, awf_q3, awf_q4} awf_phase_type;

  // request to data memory
  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic indexed;
  } awf_mem_type;

  typedef struct packed {
    logic [1:0] rst_sync;
    awf_phase_type phase;
    logic active;
    logic dest;
    logic [7:0] w;
    logic [7:0] opnd;
    logic [7:0] sum;
    logic [4:0] flags;
    logic done;
    awf_mem_type mem;
  } awf_state_type;
endpackage : awf_pkg

//--- hw/awf_exec.sv
// add-w-to-file execution unit, four quarter phases per instruction cycle
`timescale 1ns/100ps
module awf_exec
  import awf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  input wire logic [7:0] rdata,
  output awf_pkg::awf_mem_type mem,
  output logic [7:0] w_reg,
  output logic [4:0] status_flags,
  output logic done,
  output awf_pkg::awf_phase_type phase
);
  awf_state_type s;
  awf_state_type next_s;
  logic rst_n;
  logic hit;
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] faddr;

  assign rst_n = s.rst_sync[1];
  assign faddr = instr[7:0];
  // decode compares only the fixed upper bits
  assign hit = instr_valid && (instr[awf_op_hi:awf_op_lo] == awf_opcode);
  assign full = {1'b0, s.w} + {1'b0, s.opnd};
  assign low = {1'b0, s.w[3:0]} + {1'b0, s.opnd[3:0]};

  // all next-state logic; q1 decodes, q2 reads, q3 adds, q4 writes
  always_comb
  begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], 1'b1};
    next_s.phase = awf_phase_type'(s.phase + 2'd1);
    next_s.done = 1'b0;
    next_s.mem.rd = 1'b0;
    next_s.mem.wr = 1'b0;
    unique case (s.phase)
      awf_q4:
      begin
        // decode sampled at the q1 boundary so the cycle is exactly four quarters
        next_s.active = hit;
        if (hit)
        begin
          next_s.dest = instr[awf_dest_bit];
          next_s.mem.indexed = 1'b0;
          if (instr[awf_acc_bit])
            next_s.mem.addr = {bank_select_register, faddr};
          else if (ext_set_en && faddr <= awf_idx_limit)
          begin
            next_s.mem.addr = index_base + {4'h0, faddr};
            next_s.mem.indexed = 1'b1;
          end
          else if (faddr < awf_acc_split)
            next_s.mem.addr = {4'h0, faddr};
          else
            next_s.mem.addr = {awf_acc_hi_bank, faddr};
        end
      end
      awf_q1:
        next_s.mem.rd = s.active;
      awf_q2:
        if (s.active)
          next_s.opnd = rdata;
      awf_q3:
        if (s.active)
        begin
          next_s.sum = full[7:0];
          next_s.flags[awf_flag_c] = full[8];
          next_s.flags[awf_flag_dc] = low[4];
          next_s.flags[awf_flag_z] = (full[7:0] == 8'h00);
          next_s.flags[awf_flag_n] = full[7];
          next_s.flags[awf_flag_ov] = (s.w[7] == s.opnd[7]) && (full[7] != s.w[7]);
          // destination write is issued as the q4 request
          next_s.mem.wr = s.dest;
          next_s.mem.wdata = full[7:0];
        end
    endcase
    if (s.phase == awf_q4 && s.active)
    begin
      next_s.done = 1'b1;
      if (!s.dest)
        next_s.w = s.sum;
    end
  end

  // single state register; raw reset clears all, release waits for the second sync flop
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.w <= awf_w_reset;
    end
    else if (!rst_n)
    begin
      // core held quiet while the release ripples through, so no half-reset state
      s <= '0;
      s.w <= awf_w_reset;
      s.rst_sync <= next_s.rst_sync;
    end
    else
      s <= next_s;
  end

  assign mem = s.mem;
  assign w_reg = s.w;
  assign status_flags = s.flags;
  assign done = s.done;
  assign phase = s.phase;

  a_sum_to_w: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && s.active && !s.dest) |=> (w_reg == $past(s.sum)))
    else $error("working reg not loaded with sum");
  a_write_back: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active && s.dest) |=> (mem.wr && mem.wdata == $past(full[7:0])))
    else $error("file write missing");
  a_no_write_w: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active && !s.dest) |=> !mem.wr)
    else $error("file written for w destination");
  a_carry_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active) |=> (status_flags[awf_flag_c] == $past(full[8])))
    else $error("carry flag wrong");
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active) |=> (status_flags[awf_flag_z] == (s.sum == 8'h00)))
    else $error("zero flag wrong");
  a_bank_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && hit && instr[awf_acc_bit])
      |=> (mem.addr == {$past(bank_select_register), $past(faddr)}))
    else $error("banked address wrong");
  a_access_low: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && hit && !instr[awf_acc_bit] && !ext_set_en && faddr < awf_acc_split)
      |=> (mem.addr == {4'h0, $past(faddr)} && !mem.indexed))
    else $error("access bank address wrong");
  a_indexed_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && hit && !instr[awf_acc_bit] && ext_set_en && faddr <= awf_idx_limit)
      |=> mem.indexed)
    else $error("indexed mode not used");
  sequence awf_issue;
    s.phase == awf_q4 && hit;
  endsequence
  // address quarter, read quarter, then done three clocks after the read
  sequence awf_steps;
    (s.phase == awf_q1) ##1 mem.rd ##3 done;
  endsequence
  // a refused word leaves the core idle and the memory unread
  sequence awf_idle_cycle;
    !s.active ##1 !mem.rd;
  endsequence
  a_quarter_order: assert property (@(posedge clk) disable iff (!rst_n)
    awf_issue |=> awf_steps)
    else $error("quarter sequence wrong");
  // refused words must not start a read
  a_refused_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && !hit) |=> awf_idle_cycle)
    else $error("refused word started work");

  // flag values follow from the sum bits, not from the update logic
  a_neg_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active) |=> (status_flags[awf_flag_n] == $past(full[7])))
    else $error("negative flag wrong");
  // overflow is the carry into bit 7 against the carry out of it
  a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active)
      |=> (status_flags[awf_flag_ov] == $past(full[8] ^ full[7] ^ s.w[7] ^ s.opnd[7])))
    else $error("overflow flag wrong");
  // digit carry is the carry into bit 4
  a_digit_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active)
      |=> (status_flags[awf_flag_dc] == $past(full[4] ^ s.w[4] ^ s.opnd[4])))
    else $error("digit carry flag wrong");
  // registered sum is the plain eight-bit wrap of the two operands
  a_sum_value: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q3 && s.active) |=> (s.sum == $past(s.w + s.opnd)))
    else $error("sum value wrong");
  // flags move only in the process quarter of an accepted op
  a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase != awf_q3 || !s.active) |=> $stable(status_flags))
    else $error("flags changed outside process quarter");

  // working register moves only when it is the destination
  a_w_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(s.phase == awf_q4 && s.active && !s.dest) |=> $stable(w_reg))
    else $error("working reg changed unexpectedly");
  // memory write only in the write quarter of a file-destination op
  a_wr_slot: assert property (@(posedge clk) disable iff (!rst_n)
    mem.wr |-> (s.phase == awf_q4 && s.active && s.dest))
    else $error("memory write outside its slot");

  // read strobe only in the read quarter of an accepted op
  a_rd_slot: assert property (@(posedge clk) disable iff (!rst_n)
    mem.rd |-> (s.phase == awf_q2 && s.active))
    else $error("memory read outside its slot");
  // read strobe is a single-cycle pulse
  a_rd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    mem.rd |=> !mem.rd)
    else $error("read strobe too long");
  // operand is the data standing at the end of the read quarter
  a_operand_take: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q2 && s.active) |=> (s.opnd == $past(rdata)))
    else $error("operand not taken");
  // done only in the decode quarter that follows completion
  a_done_slot: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> (s.phase == awf_q1))
    else $error("done outside first quarter");
  // done is a single-cycle pulse
  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    done |=> !done)
    else $error("done too long");
  // quarter counter wraps from the write quarter to decode
  a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4) |=> (s.phase == awf_q1))
    else $error("quarter counter did not wrap");
  // quarter counter steps by one everywhere else
  a_phase_step: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase != awf_q4) |=> (s.phase == awf_phase_type'($past(s.phase) + 2'd1)))
    else $error("quarter counter skipped");
  // address stands for the whole instruction cycle
  a_addr_stands: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase != awf_q4 || !hit) |=> $stable(mem.addr))
    else $error("address moved mid cycle");

  // indexed address is base plus the file byte
  a_index_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && hit && !instr[awf_acc_bit] && ext_set_en && faddr <= awf_idx_limit)
      |=> (mem.addr == $past(index_base) + {4'h0, $past(faddr)}))
    else $error("indexed address wrong");
  // upper access half maps to the top bank whatever the extended set says
  a_access_high: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && hit && !instr[awf_acc_bit] && faddr >= awf_acc_split)
      |=> (mem.addr == {awf_acc_hi_bank, $past(faddr)} && !mem.indexed))
    else $error("upper access bank address wrong");
  // banked access never takes the indexed path
  a_bank_direct: assert property (@(posedge clk) disable iff (!rst_n)
    (s.phase == awf_q4 && hit && instr[awf_acc_bit]) |=> !mem.indexed)
    else $error("banked access marked indexed");
endmodule : awf_exec

//--- test/awf_mem_model.sv
// data memory partner model for the add-w-to-file bench
`timescale 1ns/100ps
module awf_mem_model
  import awf_pkg::*;
(
  input wire logic clk,
  input awf_pkg::awf_mem_type mem,
  output logic [7:0] rdata
);
  logic [7:0] ram [0:4095];
  logic [7:0] last;
  // address-derived fill so neighbouring cells differ, except the pair 7ffh and 800h
  initial
  begin
    for (int i = 0; i < 4096; i++)
      ram[i] = 8'(i) ^ 8'(i >> 4);
    last = 8'h00;
  end
  // released bus shows inverse of last read, never a stale copy
  assign rdata = mem.rd ? ram[mem.addr] : ~last;
  always @(posedge clk)
  begin
    if (mem.rd)
      last <= ram[mem.addr];
    if (mem.wr)
      ram[mem.addr] <= mem.wdata;
  end
endmodule : awf_mem_model

//--- test/test_awf_exec.sv
// self-checking bench for the add-w-to-file execution unit
`timescale 1ns/100ps
module test_awf_exec;
  import awf_pkg::*;
  typedef struct packed {logic [7:0] w; logic [7:0] s; logic [4:0] fl; logic [11:0] a;
    logic ix; logic d; int t;} awf_exp_type;
  logic clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0, done, lwd = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h000, lwa = 12'h000;
  logic [7:0] rdata, w_reg, wm = 8'h00, lwv = 8'h00;
  logic [4:0] status_flags;
  awf_mem_type mem;
  awf_phase_type phase;
  awf_exp_type q[$];
  awf_exp_type e;
  int err_total = 0, n_checks = 0, cyc = 0;
  logic [31:0] r;
  logic tmo = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  awf_exec dut (.clk(clk), .nrst(nrst), .instr(instr), .instr_valid(instr_valid),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
    .index_base(index_base), .rdata(rdata), .mem(mem), .w_reg(w_reg),
    .status_flags(status_flags), .done(done), .phase(phase));
  awf_mem_model mem_i (.clk(clk), .mem(mem), .rdata(rdata));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : check
  task automatic end_sim;
    if (q.size() != 0)
      err_total++;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // drive one word at the negedge before a q4 take edge; ok low sends a foreign opcode
  task automatic op(input logic [7:0] f, input logic d, a, x, input logic [3:0] b,
    input logic [11:0] ib, input logic ok);
    logic [11:0] ad;
    logic [7:0] o, s;
    logic [8:0] s9;
    int k;
    if (tmo)
      return;
    for (k = 0; k < 8 && phase !== awf_q4; k++)
      @(negedge clk);
    // a stuck quarter counter counts once, then the run drains to the report
    if (phase !== awf_q4)
    begin
      err_total++;
      tmo = 1'b1;
      return;
    end
    ad = a ? {b, f} : (x && f <= awf_idx_limit) ? ib + {4'h0, f} :
      {(f < awf_acc_split) ? 4'h0 : awf_acc_hi_bank, f};
    // previous write lands on the take edge, so forward it
    o = (lwd && ad == lwa) ? lwv : mem_i.ram[ad];
    s9 = {1'b0, wm} + {1'b0, o};
    s = s9[7:0];
    instr = {ok ? awf_opcode : 6'h08, d, a, f};
    {instr_valid, ext_set_en, bank_select_register, index_base} = {1'b1, x, b, ib};
    if (ok)
    begin
      q.push_back('{d ? wm : s, s, {s[7], wm[7] == o[7] && s[7] != wm[7], s == 8'h00,
        {1'b0, wm[3:0]} + {1'b0, o[3:0]} > 5'h0f, s9[8]}, ad, ~a & x & (f <= awf_idx_limit),
        d, cyc + 5});
      {wm, lwd, lwa, lwv} = {d ? wm : s, d, ad, s};
    end
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : op
  // monitor on the falling edge, where registered outputs have settled;
  // peek the front note at read and write, pop it at done
  always @(negedge clk)
  begin
    if (nrst && (mem.rd || mem.wr || done) && q.size() == 0)
      check("spurious", 32'h1, 32'h0);
    else if (nrst)
    begin
      if (mem.rd)
      begin
        check("addr", mem.addr, q[0].a);
        check("indexed", mem.indexed, q[0].ix);
      end
      if (mem.wr)
        check("wdata", {q[0].d, mem.wdata}, {1'b1, q[0].s});
      if (done)
      begin
        e = q.pop_front();
        check("w_reg", w_reg, e.w);
        check("flags", status_flags, e.fl);
        check("cycle", cyc, e.t);
        if (e.d)
          check("stored", mem_i.ram[e.a], e.s);
      end
    end
  end
  initial
  begin
    void'($urandom(18835));
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    op(8'h10, 1'b0, 1'b0, 1'b0, 4'h0, 12'h000, 1'b1);
    op(8'h5f, 1'b1, 1'b0, 1'b1, 4'h0, 12'h200, 1'b1);
    op(8'h60, 1'b0, 1'b0, 1'b1, 4'h0, 12'h200, 1'b1);
    op(8'h33, 1'b0, 1'b0, 1'b0, 4'h0, 12'h000, 1'b0);
    repeat (60)
    begin
      r = $urandom;
      op(r[7:0], r[8], r[9], r[10], r[14:11], r[26:15], 1'b1);
    end
    repeat (12) @(negedge clk);
    end_sim;
  end
endmodule : test_awf_exec
